/* File: core/cpu_exception_ctrl.v */
// Interrupt, halt, single step and bus-release sequencer of an 8-bit processor core.
// Assumes the execution unit reports instruction boundaries and special operations,
// and memory answers a read within the same bus cycle.
`timescale 1ns/1ns
`include "cpu_exc_defines.vh"
// Notes on behaviour
// - Maskable request is a level, taken at instruction end when mask is clear.
// - Taking an interrupt skips the fetch and stacks program counter, index, accumulators, flags.
// - After stacking, the interrupt mask is set.
// - Vector is read from FFFC/FFFD for non-maskable, FFF8/FFF9 for maskable.
// - Non-maskable requests follow the same sequence, ignoring the mask.
// - Return from interrupt restores all stacked registers including the mask.
// - Non-maskable requests are latched while halted and serviced after leaving halt.
// - Wait operation stacks early; the interrupt then just masks and fetches vector.
// - While waiting, bus released high, address valid low, buses floated.
// - Float control high floats address and read/write, forces both status outputs low.
// - After float control drops, one dead cycle, then execution resumes.
// - Address valid is never floated and high only with a genuine address.
// - Halt low before the last cycle finishes the instruction then releases the bus.
// - Bus released high floats address, data and read/write, address valid low.
// - Halt falling late in the fetch cycle lets the next instruction run too.
// - Reset while halted holds outputs idle with FFFE on the address bus.
// - After that reset, halt going high starts the FFFE/FFFF restart fetch.
// - A one-cycle halt release executes one instruction, bus released drops meanwhile.
// - Program counter, stack, index are 16 bits; accumulators and flags 8 bits.
// - Stack pointer addresses the next free stack location.
// - Mask is flags bit 4; bits 7 and 6 always read one.
// - The restart leaves the mask set.
// - Wait ends on unmasked maskable request or any non-maskable request.
module cpu_exception_ctrl (
	input wire ref_clk_i,
	input wire rst_i,
	input wire halt_n_i,
	input wire irq_n_i,
	input wire nmi_n_i,
	input wire float_control_i,
	input wire data_drive_enable_i,
	input wire instr_last_i,
	input wire fetch_cycle_i,
	input wire wait_for_interrupt_op_i,
	input wire return_from_interrupt_op_i,
	input wire [15:0] exec_addr_i,
	input wire exec_addr_valid_i,
	input wire exec_write_i,
	input wire [7:0] exec_wdata_i,
	input wire [7:0] data_i,
	input wire [7:0] flags_wr_i,
	input wire flags_we_i,
	output reg [15:0] addr_o,
	output reg addr_oe_o,
	output reg [7:0] data_o,
	output reg data_oe_o,
	output reg rw_o,
	output reg rw_oe_o,
	output reg address_valid_o,
	output reg bus_released_o,
	output reg exec_enable_o,
	output reg [15:0] program_counter_o,
	output reg [15:0] stack_pointer_o,
	output reg [15:0] index_pointer_o,
	output reg [15:0] accumulator_pair_o,
	output reg [7:0] condition_flags_o
);
	localparam [8:0] S_RUN = 9'h001;
	localparam [8:0] S_PUSH = 9'h002;
	localparam [8:0] S_MASK = 9'h004;
	localparam [8:0] S_VEC_HI = 9'h008;
	localparam [8:0] S_VEC_LO = 9'h010;
	localparam [8:0] S_WAIT = 9'h020;
	localparam [8:0] S_HALT = 9'h040;
	localparam [8:0] S_PULL = 9'h080;
	localparam [8:0] S_DEAD = 9'h100;

	wire tick;
	wire [4:0] pins;
	wire halt_n;
	wire irq_n;
	wire nmi_n;
	wire float_control;
	wire dbe;
	reg [8:0] state;
	reg [8:0] after_dead;
	reg [2:0] idx;
	reg nmi_prev;
	reg nmi_pend;
	reg vec_nmi;
	reg halt_late;
	reg rst_halted;
	reg [8:0] push_next;
	reg [7:0] vec_hi;
	reg [7:0] push_byte;
	reg [7:0] flags_mux;

	cycle_divider u_div (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	// Reset values match the idle pin levels, so no false edge or float follows reset.
	pin_sync #(.W(5), .INIT(5'h07)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({data_drive_enable_i, float_control_i, nmi_n_i, irq_n_i, halt_n_i}),
		.q_o(pins)
	);
	assign halt_n = pins[0];
	assign irq_n = pins[1];
	assign nmi_n = pins[2];
	assign float_control = pins[3];
	assign dbe = pins[4];

	wire mask = condition_flags_o[`FLAG_MASK_BIT];
	wire irq_take = !irq_n && !mask;
	wire take = nmi_pend || irq_take;
	wire halt_now = !halt_n && !halt_late;

	// Stacking order: counter low, high, index low, high, accumulators, flags.
	always @* begin
		push_byte = condition_flags_o;
		case (idx)
			3'h0: push_byte = program_counter_o[7:0];
			3'h1: push_byte = program_counter_o[15:8];
			3'h2: push_byte = index_pointer_o[7:0];
			3'h3: push_byte = index_pointer_o[15:8];
			3'h4: push_byte = accumulator_pair_o[7:0];
			3'h5: push_byte = accumulator_pair_o[15:8];
			default: push_byte = condition_flags_o;
		endcase
		flags_mux = flags_wr_i | `FLAG_ONES;
	end

	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= S_HALT;
			after_dead <= S_RUN;
			idx <= 3'h0;
			nmi_prev <= 1'b1;
			nmi_pend <= 1'b0;
			vec_nmi <= 1'b0;
			halt_late <= 1'b0;
			rst_halted <= 1'b1;
			push_next <= S_MASK;
			vec_hi <= 8'h00;
			program_counter_o <= 16'h0000;
			stack_pointer_o <= `SP_RESET;
			index_pointer_o <= 16'h0000;
			accumulator_pair_o <= 16'h0000;
			condition_flags_o <= `FLAG_RESET;
			addr_o <= `VEC_RST_HI;
			addr_oe_o <= 1'b1;
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
			rw_o <= 1'b1;
			rw_oe_o <= 1'b1;
			address_valid_o <= 1'b0;
			bus_released_o <= 1'b0;
			exec_enable_o <= 1'b0;
		end else if (tick) begin
			nmi_prev <= nmi_n;
			// A falling edge always wins over the clear on service entry.
			if (nmi_prev && !nmi_n)
				nmi_pend <= 1'b1;
			else if (state == S_MASK && vec_nmi)
				nmi_pend <= 1'b0;
			if (flags_we_i && state == S_RUN)
				condition_flags_o <= flags_mux;
			exec_enable_o <= 1'b0;
			addr_oe_o <= 1'b1;
			rw_oe_o <= 1'b1;
			rw_o <= 1'b1;
			data_oe_o <= 1'b0;
			address_valid_o <= 1'b0;
			bus_released_o <= 1'b0;
			if (float_control) begin
				addr_oe_o <= 1'b0;
				rw_oe_o <= 1'b0;
				if (state != S_DEAD)
					after_dead <= state;
				state <= S_DEAD;
			end else begin
				case (state)
				S_RUN: begin
					if (fetch_cycle_i && !halt_n)
						halt_late <= 1'b0;
					else if (fetch_cycle_i)
						halt_late <= 1'b1;
					addr_o <= exec_addr_i;
					address_valid_o <= exec_addr_valid_i;
					rw_o <= !exec_write_i;
					data_o <= exec_wdata_i;
					data_oe_o <= exec_write_i && dbe;
					exec_enable_o <= 1'b1;
					if (instr_last_i) begin
						halt_late <= 1'b0;
						if (halt_now) begin
							state <= S_HALT;
						end else if (return_from_interrupt_op_i) begin
							// The first stack address goes out now, so that the pull
							// state finds its byte on the data bus at its own tick.
							idx <= 3'h6;
							stack_pointer_o <= stack_pointer_o + 16'h0001;
							addr_o <= stack_pointer_o + 16'h0001;
							address_valid_o <= 1'b1;
							rw_o <= 1'b1;
							data_oe_o <= 1'b0;
							state <= S_PULL;
						end else if (wait_for_interrupt_op_i) begin
							idx <= 3'h0;
							push_next <= S_WAIT;
							state <= S_PUSH;
						end else if (take) begin
							vec_nmi <= nmi_pend;
							idx <= 3'h0;
							push_next <= S_MASK;
							state <= S_PUSH;
						end
					end
				end
				S_PUSH: begin
					addr_o <= stack_pointer_o;
					address_valid_o <= 1'b1;
					rw_o <= 1'b0;
					data_o <= push_byte;
					data_oe_o <= dbe;
					stack_pointer_o <= stack_pointer_o - 16'h0001;
					idx <= idx + 3'h1;
					if (idx == 3'h6)
						state <= push_next;
				end
				S_WAIT: begin
					addr_oe_o <= 1'b0;
					rw_oe_o <= 1'b0;
					bus_released_o <= 1'b1;
					if (nmi_pend || irq_take) begin
						vec_nmi <= nmi_pend;
						bus_released_o <= 1'b0;
						state <= S_MASK;
					end
				end
				S_MASK: begin
					address_valid_o <= 1'b1;
					condition_flags_o <= condition_flags_o | (8'h01 << `FLAG_MASK_BIT);
					addr_o <= vec_nmi ? `VEC_NMI_HI : `VEC_IRQ_HI;
					state <= S_VEC_HI;
				end
				S_VEC_HI: begin
					address_valid_o <= 1'b1;
					vec_hi <= data_i;
					addr_o <= addr_o | 16'h0001;
					state <= S_VEC_LO;
				end
				S_VEC_LO: begin
					program_counter_o <= {vec_hi, data_i};
					state <= S_RUN;
				end
				S_HALT: begin
					if (rst_halted) begin
						addr_o <= `VEC_RST_HI;
						if (halt_n) begin
							address_valid_o <= 1'b1;
							rst_halted <= 1'b0;
							state <= S_VEC_HI;
						end
					end else begin
						addr_oe_o <= 1'b0;
						rw_oe_o <= 1'b0;
						bus_released_o <= 1'b1;
						if (halt_n) begin
							bus_released_o <= 1'b0;
							state <= S_RUN;
						end
					end
				end
				S_PULL: begin
					case (idx)
					3'h6: condition_flags_o <= data_i | `FLAG_ONES;
					3'h5: accumulator_pair_o[15:8] <= data_i;
					3'h4: accumulator_pair_o[7:0] <= data_i;
					3'h3: index_pointer_o[15:8] <= data_i;
					3'h2: index_pointer_o[7:0] <= data_i;
					3'h1: program_counter_o[15:8] <= data_i;
					default: program_counter_o[7:0] <= data_i;
					endcase
					if (idx == 3'h0)
						state <= S_RUN;
					else begin
						idx <= idx - 3'h1;
						stack_pointer_o <= stack_pointer_o + 16'h0001;
						addr_o <= stack_pointer_o + 16'h0001;
						address_valid_o <= 1'b1;
					end
				end
				S_DEAD: begin
					// A resumed read state samples the bus at once, so the held
					// address is marked valid again before it resumes.
					if (after_dead == S_VEC_HI || after_dead == S_VEC_LO || after_dead == S_PULL)
						address_valid_o <= 1'b1;
					state <= after_dead == S_DEAD ? S_RUN : after_dead;
				end
				default: state <= S_RUN;
				endcase
			end
		end
	end
endmodule

/* File: core/cpu_exc_defines.vh */
// Constants for the interrupt, halt and bus-release control section.
// Assumes a single 20 MHz clock; one bus cycle is one enable pulse from the divider.
`ifndef CPU_EXC_DEFINES_VH
`define CPU_EXC_DEFINES_VH
`define VEC_NMI_HI 16'hfffc
`define VEC_IRQ_HI 16'hfff8
`define VEC_RST_HI 16'hfffe
`define FLAG_MASK_BIT 4
`define FLAG_ONES 8'hc0
`define FLAG_RESET 8'hd0
`define SP_RESET 16'h00ff
`define CYCLE_DIV 8'h13
`define SYNC_DEAD_CYCLES 2'h1
`endif

/* File: core/cycle_divider.v */
// Bus cycle enable divider: one pulse every CYCLE_DIV+1 reference clocks.
// Assumes ref_clk_i is free running.
`timescale 1ns/1ns
`include "cpu_exc_defines.vh"
module cycle_divider (
	input wire ref_clk_i,
	input wire rst_i,
	output reg tick_o
);
	reg [7:0] count;
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= 8'h00;
			tick_o <= 1'b0;
		end else if (count == `CYCLE_DIV) begin
			count <= 8'h00;
			tick_o <= 1'b1;
		end else begin
			count <= count + 8'h01;
			tick_o <= 1'b0;
		end
	end
endmodule

/* File: core/pin_sync.v */
// Two-flop synchronisers for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ns
module pin_sync #(
	parameter W = 5,
	parameter [4:0] INIT = 5'h00
) (
	input wire ref_clk_i,
	input wire rst_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta;
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= INIT[W-1:0];
			q_o <= INIT[W-1:0];
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

/* File: tb/cpu_exc_chk.sv */
// Port checker for the interrupt, halt and bus-release controller.
// Assumes it is bound to cpu_exception_ctrl and sees its ports only.
`timescale 1ns/1ns
module cpu_exc_chk (
	input wire ref_clk_i,
	input wire rst_i,
	input wire float_control_i,
	input wire [15:0] addr_o,
	input wire addr_oe_o,
	input wire data_oe_o,
	input wire rw_o,
	input wire rw_oe_o,
	input wire address_valid_o,
	input wire bus_released_o,
	input wire exec_enable_o,
	input wire [7:0] condition_flags_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_released_off: assert property (
		bus_released_o |-> !(address_valid_o || addr_oe_o || data_oe_o || rw_oe_o))
		else $error("released bus still driven");
	a_valid_driven: assert property (
		address_valid_o |-> addr_oe_o && rw_oe_o) else $error("valid address while floated");
	a_flag_ones: assert property (condition_flags_o[7:6] == 2'b11)
		else $error("unused flag bits not one");
	a_irq_vector: assert property (
		address_valid_o && addr_o[15:1] == 15'h7ffc |-> rw_o && condition_flags_o[4])
		else $error("maskable vector read without mask");
	a_nmi_vector: assert property (
		address_valid_o && addr_o[15:1] == 15'h7ffe |-> rw_o && condition_flags_o[4])
		else $error("non-maskable vector read without mask");
	a_float_off: assert property (
		$rose(float_control_i) |-> ##[1:45] !(address_valid_o || bus_released_o || addr_oe_o))
		else $error("float control did not release the bus");
	a_halt_still: assert property (bus_released_o |-> !exec_enable_o)
		else $error("execution while bus released");
	a_reset_idle: assert property (disable iff (1'b0)
		rst_i && $past(rst_i) |-> addr_o == 16'hfffe && rw_o && !(address_valid_o || data_oe_o))
		else $error("outputs not idle in reset");
endmodule

/* File: tb/cpu_exc_mem.sv */
// Memory model on the far side of the controller bus.
// Assumes reads are answered within the bus cycle; vectors read as address plus 0x11.
`timescale 1ns/1ns
module cpu_exc_mem (
	input wire ref_clk_i,
	input wire [15:0] addr_i,
	input wire rw_i,
	input wire address_valid_i,
	input wire [7:0] wdata_i,
	input wire wdata_oe_i,
	output wire [7:0] rdata_o
);
	reg [7:0] mem [0:255];
	reg [7:0] churn = 8'h00;
	wire [7:0] rd = addr_i[15:8] == 8'hff ? addr_i[7:0] + 8'h11 : mem[addr_i[7:0]];
	// An idle or released bus shows a changing pattern, never the last value.
	assign rdata_o = (address_valid_i && rw_i) ? rd : churn;
	always @(posedge ref_clk_i) begin
		churn <= churn + 8'h3b;
		if (address_valid_i && !rw_i && wdata_oe_i)
			mem[addr_i[7:0]] <= wdata_i;
	end
endmodule

/* File: tb/cpu_exception_ctrl_tb.sv */
// Self-checking bench for the interrupt, halt and bus-release controller.
// Assumes the checker and memory model are compiled before this file.
`timescale 1ns/1ns
module cpu_exception_ctrl_tb;
	reg ref_clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg halt_n = 1'b0;
	reg irq_n = 1'b1;
	reg nmi_n = 1'b1;
	reg flt = 1'b0;
	reg wfi = 1'b0;
	reg return_from_interrupt_op = 1'b0;
	reg fwe = 1'b0;
	reg last = 1'b1;
	reg vld = 1'b1;
	reg [7:0] fw = 8'h00;
	reg [15:0] p;
	wire [7:0] din, dout, flags;
	wire [15:0] addr, pc, sp;
	wire aoe, doe, rw, av, br;
	integer bad_count = 0;
	integer cmp_count = 0;
	cpu_exception_ctrl u_cpu_exception_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.halt_n_i(halt_n), .irq_n_i(irq_n), .nmi_n_i(nmi_n), .float_control_i(flt),
		.data_drive_enable_i(1'b1), .instr_last_i(last), .fetch_cycle_i(1'b0),
		.wait_for_interrupt_op_i(wfi), .return_from_interrupt_op_i(return_from_interrupt_op),
		.exec_addr_i(16'hff00), .exec_addr_valid_i(vld), .exec_write_i(1'b0),
		.exec_wdata_i(8'h00), .data_i(din), .flags_wr_i(fw), .flags_we_i(fwe),
		.addr_o(addr), .addr_oe_o(aoe), .data_o(dout), .data_oe_o(doe), .rw_o(rw),
		.rw_oe_o(), .address_valid_o(av), .bus_released_o(br), .exec_enable_o(),
		.program_counter_o(pc), .stack_pointer_o(sp), .index_pointer_o(),
		.accumulator_pair_o(), .condition_flags_o(flags));
	cpu_exc_mem u_mem (.ref_clk_i(ref_clk_i), .addr_i(addr), .rw_i(rw), .address_valid_i(av),
		.wdata_i(dout), .wdata_oe_i(doe), .rdata_o(din));
	initial forever #25 ref_clk_i = ~ref_clk_i;
	task check(input [23:0] seen, input [23:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task poll(input [2:0] sel, input [15:0] exp);
		integer n;
		reg [15:0] v;
		begin
			v = 16'hxxxx;
			for (n = 0; n < 2000 && v !== exp; n = n + 1) begin
				@(negedge ref_clk_i);
				v = sel == 0 ? pc : sel == 1 ? sp : sel == 2 ? {15'h0, br} :
					sel == 3 ? {15'h0, flags[4]} : {14'h0, av, aoe};
			end
			check(v, exp);
		end
	endtask
	// Holds one operation strobe for exactly one bus cycle of 20 clocks.
	task op(input [1:0] k);
		begin
			{fwe, return_from_interrupt_op, wfi} = 3'b001 << k;
			repeat (20) @(negedge ref_clk_i);
			{fwe, return_from_interrupt_op, wfi} = 3'b000;
		end
	endtask
	task t_reset;
		begin
			repeat (5) @(negedge ref_clk_i);
			check({addr, 3'b0, aoe, rw, av, br, doe}, 24'hfffe18);
			check({flags, sp}, 24'hd000ff);
			rst_i = 1'b0;
			halt_n = 1'b1;
			poll(0, 16'h0f10);
			poll(3, 16'h1);
		end
	endtask
	task t_irq;
		begin
			irq_n = 1'b0;
			repeat (200) @(negedge ref_clk_i);
			check(sp, 16'h00ff);
			p = pc;
			op(2);
			check(flags, 8'hc0);
			poll(1, 16'h00f8);
			poll(0, 16'h090a);
			check(flags[4], 1'b1);
			check({u_mem.mem[8'hfe], u_mem.mem[8'hff], u_mem.mem[8'hf9]}, {p, 8'hc0});
			irq_n = 1'b1;
			op(1);
			poll(1, 16'h00ff);
			poll(0, p);
			check(flags, 8'hc0);
		end
	endtask
	task t_halt;
		begin
			last = 1'b0;
			halt_n = 1'b0;
			repeat (60) @(negedge ref_clk_i);
			check(br, 1'b0);
			last = 1'b1;
			poll(2, 16'h1);
			nmi_n = 1'b0;
			repeat (100) @(negedge ref_clk_i);
			nmi_n = 1'b1;
			check(sp, 16'h00ff);
			fork
				begin
					halt_n = 1'b1;
					repeat (20) @(negedge ref_clk_i);
					halt_n = 1'b0;
				end
				poll(2, 16'h0);
			join
			poll(2, 16'h1);
			halt_n = 1'b1;
			poll(0, 16'h0d0e);
			poll(1, 16'h00f8);
			op(1);
			poll(1, 16'h00ff);
			poll(0, 16'h0f10);
		end
	endtask
	task t_wait;
		begin
			op(0);
			poll(2, 16'h1);
			poll(1, 16'h00f8);
			nmi_n = 1'b0;
			repeat (40) @(negedge ref_clk_i);
			nmi_n = 1'b1;
			poll(0, 16'h0d0e);
			check(sp, 16'h00f8);
			op(1);
			poll(1, 16'h00ff);
			poll(0, 16'h0f10);
		end
	endtask
	task t_float;
		begin
			// The borrowing stays short: two bus cycles.
			flt = 1'b1;
			poll(4, 16'h0);
			repeat (40) @(negedge ref_clk_i);
			flt = 1'b0;
			poll(4, 16'h3);
			vld = 1'b0;
			poll(4, 16'h1);
			vld = 1'b1;
			poll(4, 16'h3);
		end
	endtask
	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		t_reset;
		t_irq;
		t_halt;
		t_wait;
		t_float;
		end_of_test;
	end
	initial begin
		#2000000;
		bad_count = bad_count + 1;
		end_of_test;
	end
endmodule
bind cpu_exception_ctrl cpu_exc_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.float_control_i(float_control_i), .addr_o(addr_o), .addr_oe_o(addr_oe_o),
	.data_oe_o(data_oe_o), .rw_o(rw_o), .rw_oe_o(rw_oe_o), .address_valid_o(address_valid_o),
	.bus_released_o(bus_released_o), .exec_enable_o(exec_enable_o),
	.condition_flags_o(condition_flags_o));
